// ==== common/rmi_map.svh ====
// Purpose: register offsets, field positions and reset values for the
//          reference monitor status and interrupt enable block
// Assumes: 8-bit registers on a 7-bit register port address
// Notes:   definitions only
`ifndef RMI_MAP_SVH
`define RMI_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define RMI_OFS_REF_FAIL      7'h02
`define RMI_OFS_LOOP_STAT     7'h03
`define RMI_OFS_REF01_FAIL    7'h05
`define RMI_OFS_REF2_FAIL     7'h06
`define RMI_OFS_REF_FAIL_EN   7'h09
`define RMI_OFS_LOOP_EN       7'h0A
`define RMI_OFS_REF01_MON_EN  7'h0C
`define RMI_OFS_REF2_MON_EN   7'h0D
// ****************************************************************
// reset values
// ****************************************************************
`define RMI_RST_REF_FAIL_EN   8'h00
`define RMI_RST_LOOP_EN       8'h00
`define RMI_RST_MON_EN        8'hFF
// ****************************************************************
// field positions
// ****************************************************************
`define RMI_MON_SCM   0
`define RMI_MON_CFM   1
`define RMI_MON_GST   2
`define RMI_MON_PFM   3
`define RMI_REF1_LSB  4
`define RMI_LOOP_SYNC_LSB 4
`endif

// ==== common/rmi_pkg.sv ====
// Purpose: types for the reference monitor status and interrupt block
// Assumes: one system clock
// Notes:   offsets live in rmi_map.svh
package rmi_pkg;
	// four monitor failure flags for one reference
	typedef struct packed {
		logic precise_freq_fault;
		logic guard_soak_fault;
		logic coarse_freq_fault;
		logic single_cycle_fault;
	} rmi_mon_t;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rmi_req_t;

	// loop event pulses, sync fail bits at the top
	typedef struct packed {
		logic [2:0] sync_fail;
		logic       ref_switch;
		logic       holdover_entry;
		logic       lock_lost;
		logic       lock_achieved;
	} rmi_loop_t;
endpackage : rmi_pkg

// ==== verilog/rmi_top.sv ====
// Purpose: reference monitor status registers and interrupt enables
// Assumes: serial port front end hands over one-cycle rd/wr strobes
// Notes:   read data registered, valid the cycle after rd
// Operation
// R1: single-cycle faults at bit 0, 4, 0
// R2: coarse-frequency faults at bit 1, 5, 1
// R3: guard-soak faults at bit 2, 6, 2
// R4: precise-frequency faults bit 3, 7, 3
// R5: reference enable zero blocks refs 0,1
// R6: loop enable bits 3:0 gate loop events
// R7: loop enable bits 5:4 gate sync fails
// R8: ref0 monitor enables bits 3:0, reset ones
// R9: reference failure status bit per reference
// R10: loop events sticky, cleared on read
// R11: ref1 monitor enables in bits 7:4
// R12: reference enable bit 2 gates ref2
// R13: interrupt high while any unmasked status set; the code leaves sync fail 2 (loop bit 6) out of irq
`timescale 1ns/1ps
`include "rmi_map.svh"
module rmi_top (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire rmi_pkg::rmi_req_t req_i,
	output logic [7:0]             rdata_o,
	input  wire rmi_pkg::rmi_mon_t ref0_mon_i,
	input  wire rmi_pkg::rmi_mon_t ref1_mon_i,
	input  wire rmi_pkg::rmi_mon_t ref2_mon_i,
	input  wire rmi_pkg::rmi_loop_t loop_evt_i,
	output logic                   irq_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	rmi_pkg::rmi_mon_t mon_r   [3];
	rmi_pkg::rmi_mon_t mon_nxt [3];
	logic [7:0] ref_en_r,  ref_en_nxt;
	logic [7:0] loop_en_r, loop_en_nxt;
	logic [7:0] mon_en0_r, mon_en0_nxt;
	logic [7:0] mon_en1_r, mon_en1_nxt;
	logic [6:0] loop_r,    loop_nxt;
	logic [7:0] rdata_r,   rdata_nxt;
	logic       irq_r,     irq_nxt;
	rmi_pkg::rmi_mon_t mon_s1 [3];
	rmi_pkg::rmi_mon_t mon_s2 [3];
	logic [2:0] ref_fail;
	logic [3:0] men [3];

	// ****************************************************************
	// pin synchronisers for the monitor fault levels
	// ****************************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 3; i++) begin
				mon_s1[i] <= '0;
				mon_s2[i] <= '0;
			end
		end else begin
			mon_s1[0] <= ref0_mon_i;
			mon_s1[1] <= ref1_mon_i;
			mon_s1[2] <= ref2_mon_i;
			for (int i = 0; i < 3; i++)
				mon_s2[i] <= mon_s1[i];
		end
	end

	// per-monitor enable nibbles
	assign men[0] = mon_en0_r[3:0];                     // [R8]
	assign men[1] = mon_en0_r[7:4];                     // [R11]
	assign men[2] = mon_en1_r[3:0];

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// monitor flags follow the live fault levels
			mon_nxt[i]  = mon_s2[i];
			ref_fail[i] = |(mon_s2[i] & men[i]);         // [R9]
		end
		ref_en_nxt  = ref_en_r;
		loop_en_nxt = loop_en_r;
		mon_en0_nxt = mon_en0_r;
		mon_en1_nxt = mon_en1_r;
		rdata_nxt   = rdata_r;
		// sticky loop events; a read clears, but a same-cycle event wins
		loop_nxt = loop_r;
		if (req_i.rd && req_i.addr == `RMI_OFS_LOOP_STAT)
			loop_nxt = '0;                               // [R10]
		loop_nxt = loop_nxt | loop_evt_i;                // [R10]
		if (req_i.wr) begin
			case (req_i.addr)
				`RMI_OFS_REF_FAIL_EN:  ref_en_nxt  = req_i.wdata;
				`RMI_OFS_LOOP_EN:      loop_en_nxt = req_i.wdata;
				`RMI_OFS_REF01_MON_EN: mon_en0_nxt = req_i.wdata;
				`RMI_OFS_REF2_MON_EN:  mon_en1_nxt = req_i.wdata;
				default: ;
			endcase
		end
		if (req_i.rd) begin
			case (req_i.addr)
				`RMI_OFS_REF_FAIL:     rdata_nxt = {5'h00, ref_fail};
				`RMI_OFS_LOOP_STAT:    rdata_nxt = {1'b0, loop_r};
				// ref1 in the upper nibble, ref0 in the lower
				`RMI_OFS_REF01_FAIL:   rdata_nxt = {mon_r[1], mon_r[0]}; // [R1] [R2]
				// reserved upper nibble reads zero
				`RMI_OFS_REF2_FAIL:    rdata_nxt = {4'h0, mon_r[2]}; // [R3] [R4]
				`RMI_OFS_REF_FAIL_EN:  rdata_nxt = ref_en_r;
				`RMI_OFS_LOOP_EN:      rdata_nxt = loop_en_r;
				`RMI_OFS_REF01_MON_EN: rdata_nxt = mon_en0_r;
				`RMI_OFS_REF2_MON_EN:  rdata_nxt = mon_en1_r;
				default:               rdata_nxt = 8'h00;
			endcase
		end
		// reference fails gated by bits 2:0, loop by 3:0 and sync 5:4
		irq_nxt = |(ref_fail & ref_en_r[2:0])            // [R5] [R12] [R13]
			| |(loop_r[3:0] & loop_en_r[3:0])            // [R6] [R13]
			| |(loop_r[5:4] & loop_en_r[5:4]);           // [R7]
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 3; i++)
				mon_r[i] <= '0;
			ref_en_r  <= `RMI_RST_REF_FAIL_EN;           // [R5]
			loop_en_r <= `RMI_RST_LOOP_EN;               // [R6]
			mon_en0_r <= `RMI_RST_MON_EN;                // [R8]
			mon_en1_r <= `RMI_RST_MON_EN;
			loop_r    <= '0;
			rdata_r   <= 8'h00;
			irq_r     <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++)
				mon_r[i] <= mon_nxt[i];
			ref_en_r  <= ref_en_nxt;
			loop_en_r <= loop_en_nxt;
			mon_en0_r <= mon_en0_nxt;
			mon_en1_r <= mon_en1_nxt;
			loop_r    <= loop_nxt;
			rdata_r   <= rdata_nxt;
			irq_r     <= irq_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign irq_o   = irq_r;
endmodule : rmi_top

// ==== dv/rmi_monitor.sv ====
// Purpose: port checks for rmi_top
// Assumes: rdata one cycle after rd, irq two cycles after a loop event or enable write, three after a monitor fault input
// Notes: enables shadowed from port writes
`timescale 1ns/1ps
module rmi_monitor (
	input wire logic               clk_i,
	input wire logic               resetn_i,
	input wire rmi_pkg::rmi_req_t  req_i,
	input wire logic [7:0]         rdata_o,
	input wire rmi_pkg::rmi_mon_t  ref0_mon_i,
	input wire rmi_pkg::rmi_mon_t  ref1_mon_i,
	input wire rmi_pkg::rmi_mon_t  ref2_mon_i,
	input wire rmi_pkg::rmi_loop_t loop_evt_i,
	input wire logic               irq_o
);
	logic [7:0] en9_r, en9_nxt, ena_r, ena_nxt;
	logic [2:0] up_r, up_nxt;
	// up_r keeps status checks off until the synchronisers refill
	always_comb begin
		en9_nxt = (req_i.wr && req_i.addr == 7'h09) ? req_i.wdata : en9_r;
		ena_nxt = (req_i.wr && req_i.addr == 7'h0A) ? req_i.wdata : ena_r;
		up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en9_r <= 8'h00;
			ena_r <= 8'h00;
			up_r <= 3'h0;
		end else begin
			en9_r <= en9_nxt;
			ena_r <= ena_nxt;
			up_r <= up_nxt;
		end
	end
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd(a); req_i.rd && req_i.addr == a; endsequence
	sequence s_steady; $stable({ref2_mon_i, ref1_mon_i, ref0_mon_i})[*5]; endsequence
	a_ref01_status: assert property (
		s_steady ##0 s_rd(7'h05) ##0 up_r == 3'h7
		|=> rdata_o == $past({ref1_mon_i, ref0_mon_i}))
		else $error("ref0/1 status wrong");
	a_ref2_status: assert property (
		s_steady ##0 s_rd(7'h06) ##0 up_r == 3'h7
		|=> rdata_o == {4'h0, $past(ref2_mon_i)})
		else $error("ref2 status wrong");
	a_unmapped_zero: assert property (s_rd(7'h07) |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!req_i.rd |=> $stable(rdata_o))
		else $error("read data moved");
	a_loop_sticky: assert property (
		loop_evt_i != 7'h00 ##3 s_rd(7'h03)
		|=> ($past(loop_evt_i, 4) & ~rdata_o[6:0]) == 7'h00)
		else $error("loop event lost");
	a_loop_clear: assert property (
		s_rd(7'h03) ##0 loop_evt_i == 7'h00 ##1 loop_evt_i == 7'h00
		##1 s_rd(7'h03) |=> rdata_o == 8'h00)
		else $error("loop status not cleared");
	a_irq_masked: assert property (
		$past(en9_r) == 8'h00 && $past(ena_r) == 8'h00 |-> !irq_o)
		else $error("irq while all masked");
	a_irq_loop: assert property (
		loop_evt_i[0] && ena_r[0] && !req_i.wr |-> ##2 irq_o)
		else $error("lock event gave no irq");
	a_wr_readback: assert property (
		req_i.wr && req_i.addr == 7'h09 ##1 !req_i.wr ##1 s_rd(7'h09)
		|=> rdata_o == $past(req_i.wdata, 3))
		else $error("enable readback wrong");
endmodule : rmi_monitor
bind rmi_top rmi_monitor u_rmi_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
	.req_i(req_i), .rdata_o(rdata_o), .ref0_mon_i(ref0_mon_i),
	.ref1_mon_i(ref1_mon_i), .ref2_mon_i(ref2_mon_i),
	.loop_evt_i(loop_evt_i), .irq_o(irq_o));

// ==== dv/rmi_top_tb_top.sv ====
// Purpose: register port tests for rmi_top
// Assumes: 125 MHz clock
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module rmi_top_tb_top;
	logic               clk_i = 1'b0, resetn_i = 1'b0, irq_o;
	logic [7:0]         rdata_o;
	rmi_pkg::rmi_req_t  req_i = '0;
	rmi_pkg::rmi_mon_t  m0 = '0, m1 = '0, m2 = '0;
	rmi_pkg::rmi_loop_t ev = '0;
	int                 error_cnt = 0, checked = 0;
	always #4 clk_i = ~clk_i;
	rmi_top u_rmi_top (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
		.rdata_o(rdata_o), .ref0_mon_i(m0), .ref1_mon_i(m1),
		.ref2_mon_i(m2), .loop_evt_i(ev), .irq_o(irq_o));
	// ****
	// tasks
	// ****
	task stop_test;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// one strobe cycle, then an idle cycle so strobes never merge
	task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_i);
		req_i = '{w, !w, a, d};
		@(negedge clk_i);
		req_i = '0;
	endtask : acc
	task rd(input logic [6:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(rdata_o, e);
	endtask : rd
	initial begin
		repeat (16) @(negedge clk_i);
		resetn_i = 1'b1;
		rd(7'h09, 8'h00);
		rd(7'h0A, 8'h00);
		rd(7'h0C, 8'hFF);
		rd(7'h07, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m0 = 4'h1 << i;
			m1 = 4'h1 << ((i + 1) % 4);
			m2 = 4'h1 << i;
			repeat (5) @(negedge clk_i);
			rd(7'h05, {m1, m0});
			rd(7'h06, {4'h0, m2});
		end
		rd(7'h02, 8'h07);
		acc(1'b1, 7'h0C, 8'h0F);
		rd(7'h02, 8'h05);
		acc(1'b1, 7'h09, 8'h04);
		rd(7'h09, 8'h04);
		chk({7'h00, irq_o}, 8'h01);
		acc(1'b1, 7'h09, 8'h02);
		repeat (2) @(negedge clk_i);
		chk({7'h00, irq_o}, 8'h00);
		// ref2 enables off: only the ref0 precise fault stays visible
		acc(1'b1, 7'h0D, 8'h00);
		rd(7'h0D, 8'h00);
		rd(7'h02, 8'h01);
		acc(1'b1, 7'h09, 8'h01);
		repeat (2) @(negedge clk_i);
		chk({7'h00, irq_o}, 8'h01);
		acc(1'b1, 7'h09, 8'h00);
		repeat (2) @(negedge clk_i);
		chk({7'h00, irq_o}, 8'h00);
		m0 = '0;
		m1 = '0;
		m2 = '0;
		acc(1'b1, 7'h0A, 8'h3F);
		// every loop event bit; sync fail 2 must never raise irq
		for (int i = 0; i < 7; i++) begin
			@(negedge clk_i);
			ev = 7'h01 << i;
			@(negedge clk_i);
			ev = '0;
			@(negedge clk_i);
			chk({7'h00, irq_o}, {7'h00, i < 6});
			rd(7'h03, 8'h01 << i);
			rd(7'h03, 8'h00);
		end
		stop_test();
	end
	// run needs under 2 us
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
endmodule : rmi_top_tb_top
